//--- design/txei_pkg.sv
`default_nettype none
package txei_pkg;

  // Three-level selector pins
  typedef enum logic [1:0] {
    TXEI_SEL_LOW  = 2'b00,
    TXEI_SEL_MID  = 2'b01,
    TXEI_SEL_HIGH = 2'b10
  } txei_sel_t;

  localparam int unsigned TXEI_BIST_PASS_LEN  = 511;
  localparam int unsigned TXEI_WORD_SYNC_LEN  = 16;
  localparam int unsigned TXEI_LONG_PULSE_LEN = 17;
  localparam int unsigned TXEI_CNT_W          = 10;
  localparam logic [1:0]  TXEI_MODE_LL        = 2'b00;
  localparam logic [9:0]  TXEI_C0_7_CODE      = 10'h0e0;

  typedef struct packed {
    logic [7:0] data;
    logic [1:0] ctrl;
    logic       odd_parity;
    logic       ctrl_in_parity;
  } txei_char_t;

  typedef struct packed {
    logic       parity_check_control;
    txei_sel_t  rx_clock_select;
    txei_sel_t  tx_clock_select;
    logic       ref_clock_rate_select;
    logic [1:0] tx_mode_field;
    logic       bist_enable;
  } txei_cfg_t;

endpackage

`default_nettype wire

//--- design/txei_tx_error_indicator.sv
// Summary of operation
// - Parity check enabled and parity error found raises the transmit error flag.
// - Parity error flag lasts exactly one character-clock period for that character.
// - With parity check enabled, a character failing parity is replaced by code C0.7, encoded or not.
// - With self-test enabled the flag reports self-test progress.
// - Pulse once per 511-character pass, plus 16-character sync when rx select LOW.
// - Pass pulse is one period for rx select MID, seventeen for LOW or HIGH.
// - Rx select LOW or HIGH with mode LL: no sync, one-period pulse.
// - Phase-align buffer enabled unless tx select LOW with rate select LOW.
// - A fault while the buffer is enabled holds the flag until word sync sent or phase reset low.
// - Parity is odd over data, parity bit and optionally control bits.
// - Single-rate model: outputs other than buffer_enabled change only on the rising clock edge or on asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

module txei_tx_error_indicator #(
  parameter int unsigned PASS_LEN  = txei_pkg::TXEI_BIST_PASS_LEN,
  parameter int unsigned SYNC_LEN  = txei_pkg::TXEI_WORD_SYNC_LEN,
  parameter int unsigned LONG_LEN  = txei_pkg::TXEI_LONG_PULSE_LEN
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire txei_pkg::txei_cfg_t  cfg,
  input  wire logic                 char_valid,
  input  wire txei_pkg::txei_char_t char_in,
  input  wire logic                 tx_phase_reset_n,
  input  wire logic                 buffer_fault,
  input  wire logic                 word_sync_sent,
  output logic                      char_out_valid,
  output logic [9:0]                char_out,
  output logic                      char_replaced,
  output logic                      bist_sync_active,
  output logic                      buffer_enabled,
  output logic                      tx_error_flag
);
  import txei_pkg::*;

  localparam logic [TXEI_CNT_W-1:0] PASS_LAST = TXEI_CNT_W'(PASS_LEN - 1);
  localparam logic [TXEI_CNT_W-1:0] SYNC_LAST = TXEI_CNT_W'(SYNC_LEN - 1);
  localparam logic [TXEI_CNT_W-1:0] LONG_LAST = TXEI_CNT_W'(LONG_LEN - 1);

  typedef enum logic [1:0] {
    TXEI_B_IDLE    = 2'b00,
    TXEI_B_PATTERN = 2'b01,
    TXEI_B_SYNC    = 2'b10
  } txei_bist_t;

  txei_bist_t               bist_state;
  logic [TXEI_CNT_W-1:0]    bist_cnt;
  logic [TXEI_CNT_W-1:0]    pulse_cnt;
  logic                     pass_done;
  logic                     long_pulse;
  logic                     parity_bad;
  logic                     parity_pulse;
  logic                     pass_pulse;
  logic                     fault_hold;
  logic                     next_flag;
  logic                     sync_wanted;
  logic                     pass_end;
  logic                     sync_end;
  logic                     sync_sent;

  // Odd parity over data, parity bit and optionally control bits
  always_comb begin
    parity_bad = cfg.parity_check_control && char_valid &&
                 !(^{char_in.data, char_in.odd_parity,
                     char_in.ctrl & {2{char_in.ctrl_in_parity}}});
  end

  // Long pulse unless rx select MID or (mode LL)
  always_comb begin
    long_pulse = (cfg.rx_clock_select != TXEI_SEL_MID) &&
                 (cfg.tx_mode_field != TXEI_MODE_LL);
  end

  always_comb begin
    buffer_enabled = (cfg.tx_clock_select != TXEI_SEL_LOW) ||
                     cfg.ref_clock_rate_select;
  end

  // Word sync after each pass only for rx select LOW outside mode LL
  always_comb begin
    sync_wanted = (cfg.rx_clock_select == TXEI_SEL_LOW) &&
                  (cfg.tx_mode_field != TXEI_MODE_LL);
  end

  // Last character of the pattern and of the sync phase
  always_comb begin
    pass_end = (bist_state == TXEI_B_PATTERN) && (bist_cnt == PASS_LAST);
    sync_end = (bist_state == TXEI_B_SYNC) && (bist_cnt == SYNC_LAST);
  end

  // A completed self-test word sync also counts as a sent word sync
  always_comb begin
    sync_sent = word_sync_sent || (sync_end && cfg.bist_enable);
  end

  // Character path with bad characters replaced
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      char_out_valid <= 1'b0;
      char_out       <= '0;
      char_replaced  <= 1'b0;
    end else begin
      char_out_valid <= char_valid;
      char_replaced  <= parity_bad;
      if (parity_bad) begin
        char_out <= TXEI_C0_7_CODE;
      end else begin
        char_out <= {char_in.ctrl, char_in.data};
      end
    end
  end

  // One-cycle parity pulse tied to the failing character
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parity_pulse <= 1'b0;
    end else begin
      parity_pulse <= parity_bad;
    end
  end

  // Self-test pass sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bist_state <= TXEI_B_IDLE;
      bist_cnt   <= '0;
      pass_done  <= 1'b0;
    end else begin
      // Pass strobe lasts one cycle
      pass_done <= 1'b0;
      case (bist_state)
        TXEI_B_IDLE: begin
          bist_cnt <= '0;
          if (cfg.bist_enable) begin
            bist_state <= TXEI_B_PATTERN;
          end
        end
        TXEI_B_PATTERN: begin
          if (!cfg.bist_enable) begin
            bist_state <= TXEI_B_IDLE;
          end else if (pass_end) begin
            bist_cnt <= '0;
            if (sync_wanted) begin
              bist_state <= TXEI_B_SYNC;
            end else begin
              pass_done <= 1'b1;
            end
          end else begin
            bist_cnt <= bist_cnt + 1'b1;
          end
        end
        TXEI_B_SYNC: begin
          if (!cfg.bist_enable) begin
            bist_state <= TXEI_B_IDLE;
          end else if (sync_end) begin
            bist_cnt   <= '0;
            pass_done  <= 1'b1;
            bist_state <= TXEI_B_PATTERN;
          end else begin
            bist_cnt <= bist_cnt + 1'b1;
          end
        end
        default: begin
          bist_state <= TXEI_B_IDLE;
        end
      endcase
    end
  end

  // Sync phase shown to the host
  always_comb begin
    bist_sync_active = (bist_state == TXEI_B_SYNC);
  end

  // Stretch pass pulse to one or seventeen periods
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pass_pulse <= 1'b0;
      pulse_cnt  <= '0;
    end else if (pass_done) begin
      pass_pulse <= 1'b1;
      pulse_cnt  <= long_pulse ? LONG_LAST : '0;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - 1'b1;
    end else begin
      pass_pulse <= 1'b0;
    end
  end

  // Buffer fault held until sync sent or phase reset low
  // A new fault wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_hold <= 1'b0;
    end else if (buffer_enabled && buffer_fault) begin
      fault_hold <= 1'b1;
    end else if (sync_sent || !tx_phase_reset_n) begin
      fault_hold <= 1'b0;
    end
  end

  always_comb begin
    next_flag = parity_pulse || pass_pulse || fault_hold;
  end

  // Single-rate model: one edge per character period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_error_flag <= 1'b0;
    end else begin
      tx_error_flag <= next_flag;
    end
  end

endmodule

`default_nettype wire

//--- testbench/txei_props.sv
`timescale 1ns/1ps
`default_nettype none
module txei_props
  import txei_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 rst_b,
  input wire txei_pkg::txei_cfg_t  cfg,
  input wire logic                 char_valid,
  input wire txei_pkg::txei_char_t char_in,
  input wire logic                 buffer_fault,
  input wire logic                 char_out_valid,
  input wire logic [9:0]           char_out,
  input wire logic                 char_replaced,
  input wire logic                 buffer_enabled,
  input wire logic                 tx_error_flag
);
  wire bad = cfg.parity_check_control
    && !(^{char_in.data, char_in.odd_parity, char_in.ctrl & {2{char_in.ctrl_in_parity}}});
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  par_flag_a: assert property (char_valid && bad |-> ##2 tx_error_flag)
    else $error("parity flag missing");
  par_swap_a: assert property (char_valid && bad |=> char_replaced && char_out == TXEI_C0_7_CODE)
    else $error("bad char not replaced");
  char_pass_a: assert property (char_valid && !bad |=> !char_replaced
    && char_out == {$past(char_in.ctrl), $past(char_in.data)})
    else $error("good char altered");
  valid_delay_a: assert property (char_out_valid == $past(char_valid))
    else $error("valid delay wrong");
  buf_enable_a: assert property (buffer_enabled ==
    (cfg.tx_clock_select != TXEI_SEL_LOW || cfg.ref_clock_rate_select))
    else $error("buffer enable wrong");
  fault_flag_a: assert property (buffer_enabled && buffer_fault |-> ##2 tx_error_flag)
    else $error("fault not flagged");
  reset_low_a: assert property ($rose(rst_b) |-> !tx_error_flag)
    else $error("flag high after reset");
  bist_short_a: assert property ($rose(tx_error_flag) && cfg.bist_enable
    && cfg.rx_clock_select == TXEI_SEL_MID && !$past(char_valid) && !$past(char_valid, 2)
    && !$past(buffer_fault) && !$past(buffer_fault, 2) |=> !tx_error_flag)
    else $error("pass pulse too long");
  par_once_a: assert property (char_valid && bad && !buffer_enabled && !tx_error_flag
    && !cfg.bist_enable && !$past(cfg.bist_enable)
    ##1 !char_valid && !buffer_enabled && !tx_error_flag |=> tx_error_flag ##1 !tx_error_flag)
    else $error("parity flag not one cycle");
endmodule
`default_nettype wire

//--- testbench/txei_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module txei_host_model
  import txei_pkg::*;
(
  input  wire logic                word,
  input  wire logic [9:0]          value,
  input  wire logic                with_ctrl,
  input  wire logic                corrupt,
  output var txei_pkg::txei_char_t char_out
);
  // Odd parity over data and optional control bits
  // Idle bus shows zero between characters
  assign char_out = word ? txei_char_t'{data: value[7:0], ctrl: value[9:8],
    ctrl_in_parity: with_ctrl,
    odd_parity: ~^{value[7:0], value[9:8] & {2{with_ctrl}}} ^ corrupt} : '0;
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import txei_pkg::*;
  logic       clk = 0, rst_b = 0, cv = 0, prn = 1, bf = 0, wss = 0, wc = 0, bad = 0;
  logic [9:0] w = '0, co;
  txei_cfg_t  cfg = '0;
  txei_char_t ch;
  logic       cov, rep, sync, ben, flag;
  int         failures = 0, checks_done = 0, cyc = 0, n, s;
  txei_host_model host (.word(cv), .value(w), .with_ctrl(wc), .corrupt(bad), .char_out(ch));
  localparam int PASS_N = 8, SYNC_N = 4, LONG_N = 3;
  txei_tx_error_indicator #(.PASS_LEN(PASS_N), .SYNC_LEN(SYNC_N), .LONG_LEN(LONG_N)) dut (
    .clk(clk), .rst_b(rst_b), .cfg(cfg), .char_valid(cv), .char_in(ch), .tx_phase_reset_n(prn),
    .buffer_fault(bf), .word_sync_sent(wss), .char_out_valid(cov), .char_out(co),
    .char_replaced(rep), .bist_sync_active(sync), .buffer_enabled(ben), .tx_error_flag(flag));
  initial forever #25 clk = ~clk;
  task automatic tick(int k = 1);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(logic [9:0] seen, logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic send(logic [9:0] v, logic c, logic b, logic e);
    w = v;
    wc = c;
    bad = b;
    cv = 1;
    tick();
    cv = 0;
    chk(co, e ? TXEI_C0_7_CODE : v);
    chk(rep, e);
    chk(cov, 1);
    tick();
    chk(flag, e);
    tick();
    chk(flag, 0);
    $display("char test done");
  endtask
  task automatic fault(logic e);
    bf = 1;
    tick();
    bf = 0;
    tick(4);
    chk(flag, e);
    chk(ben, e);
    prn = 0;
    tick();
    prn = 1;
    tick(3);
    chk(flag, 0);
    $display("fault test done");
  endtask
  task automatic bist(txei_sel_t rx, logic [1:0] m, int len, int sl);
    cfg.rx_clock_select = rx;
    cfg.tx_mode_field = m;
    cfg.bist_enable = 1;
    n = 0;
    s = 0;
    while (flag !== 1 && n < 60) begin
      s += sync;
      tick();
      n++;
    end
    n = 0;
    while (flag === 1 && n < 60) begin
      tick();
      n++;
    end
    chk(10'(n), 10'(len));
    chk(10'(s), 10'(sl));
    while (flag !== 1 && n < 60) begin
      tick();
      n++;
    end
    chk(10'(n), 10'(PASS_N + sl));
    cfg.bist_enable = 0;
    tick(20);
    $display("self-test done");
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    tick(8);
    rst_b = 1;
    tick();
    chk(flag, 0);
    cfg.parity_check_control = 1;
    send(10'h2a5, 0, 0, 0);
    send(10'h15a, 1, 1, 1);
    send(10'h3c3, 1, 0, 0);
    cfg.parity_check_control = 0;
    send(10'h033, 0, 1, 0);
    fault(0);
    cfg.ref_clock_rate_select = 1;
    fault(1);
    cfg.tx_clock_select = TXEI_SEL_MID;
    fault(1);
    bf = 1;
    tick();
    bf = 0;
    wss = 1;
    tick();
    wss = 0;
    tick(3);
    chk(flag, 0);
    bist(TXEI_SEL_MID, 2'b01, 1, 0);
    bist(TXEI_SEL_HIGH, 2'b01, LONG_N, 0);
    bist(TXEI_SEL_HIGH, TXEI_MODE_LL, 1, 0);
    bist(TXEI_SEL_LOW, TXEI_MODE_LL, 1, 0);
    bist(TXEI_SEL_LOW, 2'b01, LONG_N, SYNC_N);
    complete_run();
  end
endmodule
bind txei_tx_error_indicator txei_props props_i (.clk(clk), .rst_b(rst_b), .cfg(cfg),
  .char_valid(char_valid), .char_in(char_in), .buffer_fault(buffer_fault),
  .char_out_valid(char_out_valid), .char_out(char_out), .char_replaced(char_replaced),
  .buffer_enabled(buffer_enabled), .tx_error_flag(tx_error_flag));
`default_nettype wire
